// ### rtl/ssc_sequencer.sv
`include "ssc_cfg.svh"
`default_nettype none

module ssc_sequencer #(
  parameter int unsigned INIT_CYC  = `SSC_INIT_CYC,
  parameter int unsigned PWRUP_CYC = `SSC_PWRUP_CYC
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic linkClk,
  input  wire logic sleep_request_low,
  input  wire logic reconfigure_request_low,
  input  wire logic coreSupplyOk,
  input  wire logic cfgValid,
  input  wire logic cfgBit,
  output logic      config_master_clock,
  output logic      initFlag,
  output logic      configDone,
  output logic      userIoEnable,
  output logic      fabricRun,
  output logic      asleep
);

  localparam int          SleepMin  = `SSC_SLEEP_MIN_CYC;
  localparam int          PrgMin    = `SSC_PRG_MIN_CYC;
  localparam logic [10:0] HdrEnd    = 11'(`SSC_HDR_BITS);
  localparam logic [10:0] RateEnd   = 11'(`SSC_HDR_BITS + `SSC_RATE_BITS);
  localparam logic [10:0] LoadEnd   = 11'(`SSC_LOAD_BITS);
  localparam logic [6:0]  WakeEdges = 7'(`SSC_WAKE_CONFIG_MASTER_CLOCK);
  localparam logic [6:0]  WakeIo    = 7'(`SSC_WAKE_IO_EDGE);

  ssc_pkg::ssc_state_t st_q;
  ssc_pkg::ssc_state_t stD;
  ssc_pkg::ssc_rate_t  rateSel_q;
  ssc_pkg::ssc_rate_t  rateWord_q;
  logic [3:0]          rateSh_q;
  logic [10:0]         bitCnt_q;
  logic [23:0]         cnt_q;
  logic [6:0]          wakeCnt_q;
  logic                linkRstS1_q;
  logic                linkRst_q;
  logic                epoch_q;
  logic                epS1_q;
  logic                epS2_q;
  logic                epSeen_q;
  logic                rateTog_q;
  logic                doneTog_q;
  logic                rtS1_q;
  logic                rtS2_q;
  logic                rtS3_q;
  logic                dnS1_q;
  logic                dnS2_q;
  logic                dnS3_q;
  logic                supS1_q;
  logic                supS2_q;
  logic                rateEvt;
  logic                doneEvt;
  logic                sleepLow;
  logic                sleepQual;
  logic                progLow;
  logic                progHold;
  logic                progQual;
  logic                initFlag_q;
  logic                configDone_q;
  logic                ioEn_q;
  logic                fabricRun_q;
  logic                run_q;
  logic [7:0]          sleepRun_q;

  ssc_config_master_clock_if cif ();

  // ----------------------------------------------------------------------
  // pin qualification
  // ----------------------------------------------------------------------

  // sleep pin synchroniser and width counter
  ssc_pin_qual #(
    .REJ_CYC (`SSC_SLEEP_REJ_CYC),
    .MIN_CYC (SleepMin)
  ) u_sleep_qual (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .pinLowN    (sleep_request_low),
    .pinLow     (sleepLow),
    .pastReject (),
    .qualified  (sleepQual)
  );

  // glitch filter and start width on program pin
  ssc_pin_qual #(
    .REJ_CYC (`SSC_PRG_REJ_CYC),
    .MIN_CYC (PrgMin)
  ) u_prog_qual (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .pinLowN    (reconfigure_request_low),
    .pinLow     (progLow),
    .pastReject (progHold),
    .qualified  (progQual)
  );

  // supply-good level crossing
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      supS1_q <= 1'b0;
      supS2_q <= 1'b0;
    end else begin
      supS1_q <= coreSupplyOk;
      supS2_q <= supS1_q;
    end
  end

  // ----------------------------------------------------------------------
  // link domain: bitstream header capture
  // ----------------------------------------------------------------------

  // reset and restart epoch brought onto the link clock
  always_ff @(posedge linkClk) begin
    linkRstS1_q <= sys_rst;
    linkRst_q   <= linkRstS1_q;
    epS1_q      <= epoch_q;
    epS2_q      <= epS1_q;
  end

  // bit counter, rate field and end-of-load toggles
  always_ff @(posedge linkClk) begin
    if (linkRst_q) begin
      bitCnt_q   <= 11'h000;
      epSeen_q   <= 1'b0;
      rateSh_q   <= 4'h0;
      rateWord_q <= `SSC_RATE_DEFAULT;
      rateTog_q  <= 1'b0;
      doneTog_q  <= 1'b0;
    end else if (epS2_q != epSeen_q) begin
      epSeen_q <= epS2_q;
      bitCnt_q <= 11'h000;
    end else if (cfgValid && bitCnt_q != LoadEnd) begin
      bitCnt_q <= bitCnt_q + 11'h001;
      if (bitCnt_q >= HdrEnd && bitCnt_q < RateEnd) begin
        rateSh_q <= {rateSh_q[2:0], cfgBit};
      end
      if (bitCnt_q == RateEnd - 11'h001) begin
        rateWord_q <= {rateSh_q, cfgBit};
        rateTog_q  <= ~rateTog_q;
      end
      if (bitCnt_q == LoadEnd - 11'h001) begin
        doneTog_q <= ~doneTog_q;
      end
    end
  end

  // toggle events back into the system domain
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {rtS1_q, rtS2_q, rtS3_q} <= 3'h0;
      {dnS1_q, dnS2_q, dnS3_q} <= 3'h0;
    end else begin
      {rtS1_q, rtS2_q, rtS3_q} <= {rateTog_q, rtS1_q, rtS2_q};
      {dnS1_q, dnS2_q, dnS3_q} <= {doneTog_q, dnS1_q, dnS2_q};
    end
  end

  assign rateEvt = rtS2_q ^ rtS3_q;
  assign doneEvt = dnS2_q ^ dnS3_q;

  // ----------------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------------

  // next state
  always_comb begin
    stD = st_q;
    case (st_q)
      ssc_pkg::ST_POR: begin
        if (supS2_q && cnt_q == 24'(INIT_CYC - 1)) begin
          stD = ssc_pkg::ST_LOAD;
        end
      end
      ssc_pkg::ST_CLEAR: begin
        if (!progLow) begin
          stD = ssc_pkg::ST_LOAD;
        end
      end
      ssc_pkg::ST_LOAD: begin
        if (doneEvt) begin
          stD = ssc_pkg::ST_WAKE;
        end
      end
      ssc_pkg::ST_WAKE: begin
        if (cif.rise && wakeCnt_q == WakeEdges - 7'h01) begin
          stD = ssc_pkg::ST_USER;
        end
      end
      ssc_pkg::ST_USER: begin
        // sleep entry only from the pin
        if (sleepQual) begin
          stD = ssc_pkg::ST_SLEEP;
        end
      end
      ssc_pkg::ST_SLEEP: begin
        if (!sleepLow) begin
          stD = ssc_pkg::ST_PWRUP;
        end
      end
      ssc_pkg::ST_PWRUP: begin
        if (sleepQual) begin
          stD = ssc_pkg::ST_SLEEP;
        end else if (cnt_q == 24'(PWRUP_CYC - 1)) begin
          stD = ssc_pkg::ST_USER;
        end
      end
      default: stD = ssc_pkg::ST_POR;
    endcase
    if (progQual && st_q != ssc_pkg::ST_SLEEP && st_q != ssc_pkg::ST_PWRUP) begin
      stD = ssc_pkg::ST_CLEAR;
    end
    if (!supS2_q) begin
      stD = ssc_pkg::ST_POR;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= ssc_pkg::ST_POR;
    end else begin
      st_q <= stD;
    end
  end

  // delay counter for init and power-up, cleared on every state change
  always_ff @(posedge clock) begin
    if (sys_rst || stD != st_q) begin
      cnt_q <= 24'h000000;
    end else if (cnt_q != 24'hffffff && (st_q != ssc_pkg::ST_POR || supS2_q)) begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end

  // wake-up master clock edge counter
  always_ff @(posedge clock) begin
    if (sys_rst || st_q != ssc_pkg::ST_WAKE) begin
      wakeCnt_q <= 7'h00;
    end else if (cif.rise) begin
      wakeCnt_q <= wakeCnt_q + 7'h01;
    end
  end

  // restart epoch flips on each load entry so the link side clears its count
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      epoch_q <= 1'b0;
    end else if (stD == ssc_pkg::ST_LOAD && st_q != ssc_pkg::ST_LOAD) begin
      epoch_q <= ~epoch_q;
    end
  end

  // ----------------------------------------------------------------------
  // master clock control
  // ----------------------------------------------------------------------

  // default at load entry, switch on rate event, table range check
  always_ff @(posedge clock) begin
    if (sys_rst || st_q != ssc_pkg::ST_LOAD && stD == ssc_pkg::ST_LOAD) begin
      rateSel_q <= `SSC_RATE_DEFAULT;
    end else if (st_q == ssc_pkg::ST_LOAD && rateEvt) begin
      rateSel_q <= (rateWord_q < 5'(`SSC_RATE_COUNT)) ? rateWord_q : `SSC_RATE_DEFAULT;
    end
  end

  // clock runs from init high through wake-up
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= (stD == ssc_pkg::ST_LOAD) || (stD == ssc_pkg::ST_WAKE);
    end
  end

  assign cif.run     = run_q;
  assign cif.rateIdx = rateSel_q;

  ssc_config_master_clock_gen u_config_master_clock (
    .clock               (clock),
    .sys_rst             (sys_rst),
    .cif                 (cif),
    .config_master_clock (config_master_clock)
  );

  // ----------------------------------------------------------------------
  // status flags and I/O control
  // ----------------------------------------------------------------------

  // fabric stops in sleep; sleep requests are taken only in user and power-up, program requests in all states but sleep and power-up
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      initFlag_q   <= 1'b0;
      configDone_q <= 1'b0;
      fabricRun_q  <= 1'b0;
    end else begin
      initFlag_q   <= stD != ssc_pkg::ST_POR && stD != ssc_pkg::ST_CLEAR;
      configDone_q <= stD == ssc_pkg::ST_WAKE || stD == ssc_pkg::ST_USER ||
                      stD == ssc_pkg::ST_SLEEP || stD == ssc_pkg::ST_PWRUP;
      fabricRun_q  <= stD == ssc_pkg::ST_USER;
    end
  end

  // I/Os released one cycle after the chosen wake-up clock edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ioEn_q <= 1'b0;
    end else if (stD == ssc_pkg::ST_WAKE) begin
      // leaving wake-up for any state but user drops the enable at once
      ioEn_q <= ioEn_q || (cif.rise && wakeCnt_q == WakeIo - 7'h01);
    end else begin
      ioEn_q <= stD == ssc_pkg::ST_USER;
    end
  end

  // fast tri-state paths bypass the state machine; initFlag and configDone likewise
  assign userIoEnable = ioEn_q && !progHold && !(sleepLow && st_q == ssc_pkg::ST_USER);
  assign initFlag     = initFlag_q && !progHold;
  assign configDone   = configDone_q && !progHold;
  assign fabricRun    = fabricRun_q;
  assign asleep       = st_q == ssc_pkg::ST_SLEEP;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------

  // consecutive low samples of the sleep pin
  always_ff @(posedge clock) begin
    if (sys_rst || !sleepLow) begin
      sleepRun_q <= 8'h00;
    end else if (sleepRun_q != 8'hff) begin
      sleepRun_q <= sleepRun_q + 8'h01;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence progFall;
    $rose(progHold);
  endsequence

  sequence wakeLeave;
    st_q == ssc_pkg::ST_WAKE ##1 st_q == ssc_pkg::ST_USER;
  endsequence

  sleep_width_a: assert property (
    sleepQual |-> sleepRun_q == 8'(SleepMin - 1))
    else $error("sleep taken before minimum width");

  sleep_entry_a: assert property (
    (sleepQual && st_q == ssc_pkg::ST_USER && supS2_q && !progQual) |=>
    st_q == ssc_pkg::ST_SLEEP ##1 !fabricRun && !userIoEnable)
    else $error("sleep request not honoured");

  sleep_tristate_a: assert property (
    (sleepLow && st_q == ssc_pkg::ST_USER) |-> !userIoEnable)
    else $error("I/O still driven with sleep low");

  sleep_in_load_a: assert property (
    (st_q == ssc_pkg::ST_LOAD) |=> st_q != ssc_pkg::ST_SLEEP)
    else $error("sleep entered during load");

  pwrup_time_a: assert property (
    (st_q == ssc_pkg::ST_PWRUP) |-> cnt_q < 24'(PWRUP_CYC))
    else $error("power-up too long");

  prog_flags_a: assert property (
    progFall |-> !initFlag && !configDone && !userIoEnable)
    else $error("flags not dropped on program");

  prog_start_a: assert property (
    (progQual && supS2_q && st_q != ssc_pkg::ST_SLEEP && st_q != ssc_pkg::ST_PWRUP)
    |=> st_q == ssc_pkg::ST_CLEAR && !initFlag_q)
    else $error("program did not restart");

  rate_default_a: assert property (
    (st_q != ssc_pkg::ST_LOAD && stD == ssc_pkg::ST_LOAD) |=>
    cif.rateIdx == `SSC_RATE_DEFAULT && cif.run)
    else $error("load not started at default rate");

  wake_cycles_a: assert property (
    wakeLeave |-> $past(wakeCnt_q) == WakeEdges - 7'h01 && $past(configDone_q, 1))
    else $error("too few wake-up clocks");

  io_release_a: assert property (
    ($rose(ioEn_q) && st_q == ssc_pkg::ST_WAKE) |-> $past(cif.rise))
    else $error("I/O release not tied to clock edge");

  mclk_valid_a: assert property (
    $rose(initFlag_q) |-> ##[1:8] cif.rise)
    else $error("no master clock after init");

  por_tristate_a: assert property (
    !supS2_q |=> !userIoEnable && !fabricRun)
    else $error("I/O driven without supply");

endmodule

`default_nettype wire

// ### rtl/ssc_cfg.svh
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

// ----------------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------------
`define SSC_CLK_NS          4
`define SSC_CYC_CEIL(t)     (((t) + `SSC_CLK_NS - 1) / `SSC_CLK_NS)
`define SSC_CYC_FLOOR(t)    ((t) / `SSC_CLK_NS)

// ----------------------------------------------------------------------
// pin timing, in ns as printed
// ----------------------------------------------------------------------
`define SSC_T_SLEEP_MIN_NS  400
`define SSC_T_SLEEP_REJ_NS  120
`define SSC_T_PRG_MIN_NS    25
`define SSC_T_PRG_REJ_NS    7
`define SSC_T_PWRUP_MAX_NS  1800000
`define SSC_T_INIT_MAX_NS   50000000
`define SSC_T_MCLK_MAX_NS   2000

// ----------------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------------
`define SSC_SLEEP_MIN_CYC   `SSC_CYC_CEIL(`SSC_T_SLEEP_MIN_NS)
`define SSC_SLEEP_REJ_CYC   `SSC_CYC_FLOOR(`SSC_T_SLEEP_REJ_NS)
`define SSC_PRG_MIN_CYC     `SSC_CYC_CEIL(`SSC_T_PRG_MIN_NS)
`define SSC_PRG_REJ_CYC     `SSC_CYC_CEIL(`SSC_T_PRG_REJ_NS)
`define SSC_PWRUP_CYC       `SSC_CYC_FLOOR(`SSC_T_PWRUP_MAX_NS)
`define SSC_INIT_CYC        `SSC_CYC_FLOOR(`SSC_T_INIT_MAX_NS)
`define SSC_MCLK_CYC        `SSC_CYC_FLOOR(`SSC_T_MCLK_MAX_NS)

// ----------------------------------------------------------------------
// wake-up and bitstream layout
// ----------------------------------------------------------------------
`define SSC_WAKE_CONFIG_MASTER_CLOCK       120
`define SSC_WAKE_IO_EDGE    2
`define SSC_HDR_BITS        16
`define SSC_RATE_BITS       5
`define SSC_LOAD_BITS       1024
`define SSC_RATE_COUNT      19
`define SSC_RATE_DEFAULT    5'h00

`endif

// ### rtl/ssc_pkg.sv
`default_nettype none

package ssc_pkg;

  typedef logic [4:0] ssc_rate_t;
  typedef logic [7:0] ssc_div_t;

  typedef enum logic [2:0] {
    ST_POR,
    ST_CLEAR,
    ST_LOAD,
    ST_WAKE,
    ST_USER,
    ST_SLEEP,
    ST_PWRUP
  } ssc_state_t;

  // master clock period in system cycles per rate index
  function automatic ssc_div_t config_master_clock_period(input ssc_rate_t idx);
    case (idx)
      5'h00:   return 8'h64;
      5'h01:   return 8'h3a;
      5'h02:   return 8'h2e;
      5'h03:   return 8'h24;
      5'h04:   return 8'h1f;
      5'h05:   return 8'h1b;
      5'h06:   return 8'h19;
      5'h07:   return 8'h13;
      5'h08:   return 8'h11;
      5'h09:   return 8'h0d;
      5'h0a:   return 8'h0a;
      5'h0b:   return 8'h08;
      5'h0c:   return 8'h07;
      5'h0d:   return 8'h06;
      5'h0e:   return 8'h06;
      5'h0f:   return 8'h05;
      5'h10:   return 8'h05;
      5'h11:   return 8'h04;
      5'h12:   return 8'h02;
      default: return 8'h64;
    endcase
  endfunction

endpackage

`default_nettype wire

// ### rtl/ssc_config_master_clock_if.sv
`default_nettype none

interface ssc_config_master_clock_if;
  logic              run;
  ssc_pkg::ssc_rate_t rateIdx;
  logic              rise;

  modport ctl (output run, output rateIdx, input rise);
  modport gen (input run, input rateIdx, output rise);
endinterface

`default_nettype wire

// ### rtl/ssc_pin_qual.sv
`include "ssc_cfg.svh"
`default_nettype none

module ssc_pin_qual #(
  parameter int unsigned REJ_CYC = 1,
  parameter int unsigned MIN_CYC = 2
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic pinLowN,
  output logic      pinLow,
  output logic      pastReject,
  output logic      qualified
);

  logic       s1_q;
  logic       s2_q;
  logic [7:0] cnt_q;

  // two-stage synchroniser, idle high
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= pinLowN;
      s2_q <= s1_q;
    end
  end

  // low-width counter, saturates at the minimum width
  always_ff @(posedge clock) begin
    if (sys_rst || s2_q) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'(MIN_CYC)) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign pinLow     = ~s2_q;
  assign pastReject = ~s2_q && (cnt_q >= 8'(REJ_CYC));
  assign qualified  = ~s2_q && (cnt_q == 8'(MIN_CYC - 1));

endmodule

`default_nettype wire

// ### rtl/ssc_config_master_clock_gen.sv
`include "ssc_cfg.svh"
`default_nettype none

module ssc_config_master_clock_gen (
  input  wire logic clock,
  input  wire logic sys_rst,
  ssc_config_master_clock_if.gen   cif,
  output logic      config_master_clock
);

  ssc_pkg::ssc_div_t per_q;
  ssc_pkg::ssc_div_t perD;
  ssc_pkg::ssc_div_t cnt_q;
  ssc_pkg::ssc_div_t cntD;
  logic              run_q;
  logic              config_master_clock_q;
  logic              rise_q;

  // new period is taken only at a period boundary or while the clock is stopped, so switching is glitch free
  always_comb begin
    perD = per_q;
    cntD = cnt_q + 8'h01;
    if (!cif.run || !run_q || cnt_q == per_q - 8'h01) begin
      cntD = 8'h00;
      perD = ssc_pkg::config_master_clock_period(cif.rateIdx);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      per_q  <= ssc_pkg::config_master_clock_period(`SSC_RATE_DEFAULT);
      cnt_q  <= 8'h00;
      run_q  <= 1'b0;
      config_master_clock_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      per_q  <= perD;
      cnt_q  <= cntD;
      run_q  <= cif.run;
      config_master_clock_q <= cif.run && (cntD < (perD >> 1));
      rise_q <= cif.run && (cntD == 8'h00);
    end
  end

  assign cif.rise            = rise_q;
  assign config_master_clock = config_master_clock_q;

  config_master_clock_duty_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (config_master_clock_q && run_q) |-> (cnt_q < (per_q >> 1)) && (per_q >= 8'h02))
    else $error("master clock high phase too long");

endmodule

`default_nettype wire

// ### tb/ssc_ctl_model.sv
`default_nettype none

// ----------------------------------------------------------------------
// system controller: pins and bitstream link
// ----------------------------------------------------------------------
module ssc_ctl_model (
  input  wire logic clock,
  output logic      linkClk,
  output logic      cfgValid,
  output logic      cfgBit,
  output logic      sleep_request_low,
  output logic      reconfigure_request_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle levels, link clock stands still
  initial begin
    linkClk = 1'b0;
    cfgValid = 1'b0;
    cfgBit = 1'b0;
    sleep_request_low = 1'b1;
    reconfigure_request_low = 1'b1;
  end

  // n link periods, data launched on the fall
  task automatic ticks(input int n);
    repeat (n) begin
      #40 linkClk = 1'b1;
      #40 linkClk = 1'b0;
    end
  endtask

  // low pulse of a set width
  task automatic pinLow(input bit sel, input int cyc);
    if (sel) sleep_request_low <= 1'b0;
    else reconfigure_request_low <= 1'b0;
    repeat (cyc) @(posedge clock);
    sleep_request_low <= 1'b1;
    reconfigure_request_low <= 1'b1;
  endtask

  task automatic frame(input logic [4:0] rate);
    int b;
    #1.3;
    for (int i = 0; i < 1027; i++) begin
      b = i - 3;
      cfgValid = (b >= 0);
      cfgBit = (b >= 16 && b <= 20) ? rate[20 - b] : ~cfgBit;
      ticks(1);
    end
    cfgValid = 1'b0;
    cfgBit = ~cfgBit;
  endtask
endmodule

`default_nettype wire

// ### tb/tb.sv
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int INIT_C = 20;
  localparam int PWR_C  = 30;

  logic clock, sys_rst, coreSupplyOk, linkClk, cfgValid, cfgBit, slpN, prgN;
  logic mclk, initFlag, configDone, userIoEnable, fabricRun, asleep;
  int   err_total, cmp_count, cycles, n, wakeRises;
  logic mclkPrev;

  // ----------------------------------------------------------------------
  // design and controller
  // ----------------------------------------------------------------------
  ssc_sequencer #(.INIT_CYC(INIT_C), .PWRUP_CYC(PWR_C)) u_ssc_sequencer (
    .clock(clock), .sys_rst(sys_rst), .linkClk(linkClk),
    .sleep_request_low(slpN), .reconfigure_request_low(prgN),
    .coreSupplyOk(coreSupplyOk), .cfgValid(cfgValid), .cfgBit(cfgBit),
    .config_master_clock(mclk), .initFlag(initFlag), .configDone(configDone),
    .userIoEnable(userIoEnable), .fabricRun(fabricRun), .asleep(asleep));

  ssc_ctl_model u_ssc_ctl_model (
    .clock(clock), .linkClk(linkClk), .cfgValid(cfgValid), .cfgBit(cfgBit),
    .sleep_request_low(slpN), .reconfigure_request_low(prgN));

  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // master clock rises seen between done high and fabric start
  always @(posedge clock) begin
    mclkPrev <= mclk;
    if (configDone !== 1'b1) begin
      wakeRises <= 0;
    end else if (mclk === 1'b1 && mclkPrev === 1'b0 && fabricRun !== 1'b1) begin
      wakeRises <= wakeRises + 1;
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // cycles until the master clock rises
  task automatic waitRise(output int k);
    logic p;
    k = 0;
    do begin
      p = mclk;
      step(1);
      k++;
    end while (!(p === 1'b0 && mclk === 1'b1) && k < 600);
  endtask

  task automatic waitHi(ref logic s, input int lim, output int k);
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      step(1);
      k++;
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic powerOn();
    coreSupplyOk <= 1'b1;
    waitHi(initFlag, INIT_C + 40, n);
    `CHK(n <= INIT_C + 10, 1'b1)
    `CHK(userIoEnable, 1'b0)
    waitRise(n);
    `CHK(n <= 500, 1'b1)
    waitRise(n);
    `CHK(n, 100)
    $display("test powerOn done");
  endtask

  task automatic configRun();
    u_ssc_ctl_model.frame(5'h0a);
    waitHi(configDone, 200, n);
    `CHK(configDone, 1'b1)
    waitRise(n);
    waitRise(n);
    `CHK(n, 10)
    n = 0;
    while (fabricRun !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    `CHK(wakeRises >= 120, 1'b1)
    `CHK(userIoEnable, 1'b1)
    $display("test configRun done");
  endtask

  task automatic sleepShort();
    fork
      u_ssc_ctl_model.pinLow(1'b1, 30);
      begin
        step(7);
        `CHK(userIoEnable, 1'b0)
      end
    join
    step(6);
    `CHK(asleep, 1'b0)
    `CHK(fabricRun, 1'b1)
    `CHK(userIoEnable, 1'b1)
    $display("test sleepShort done");
  endtask

  task automatic sleepLong();
    fork
      u_ssc_ctl_model.pinLow(1'b1, 110);
      begin
        step(105);
        `CHK(asleep, 1'b1)
        `CHK(fabricRun, 1'b0)
        `CHK(userIoEnable, 1'b0)
      end
    join
    step(PWR_C + 8);
    `CHK(asleep, 1'b0)
    `CHK(fabricRun, 1'b1)
    $display("test sleepLong done");
  endtask

  task automatic progPins();
    u_ssc_ctl_model.pinLow(1'b0, 2);
    step(6);
    `CHK(configDone, 1'b1)
    `CHK(userIoEnable, 1'b1)
    fork
      u_ssc_ctl_model.pinLow(1'b0, 12);
      begin
        step(6);
        `CHK(initFlag, 1'b0)
        `CHK(configDone, 1'b0)
        `CHK(userIoEnable, 1'b0)
      end
    join
    waitHi(initFlag, 20, n);
    `CHK(initFlag, 1'b1)
    waitRise(n);
    waitRise(n);
    `CHK(n, 100)
    // out-of-table rate index keeps the default clock
    u_ssc_ctl_model.frame(5'h13);
    waitRise(n);
    waitRise(n);
    `CHK(n, 100)
    coreSupplyOk <= 1'b0;
    step(6);
    `CHK(initFlag, 1'b0)
    `CHK(userIoEnable, 1'b0)
    $display("test progPins done");
  endtask

  // main sequence
  initial begin
    sys_rst = 1'b1;
    coreSupplyOk = 1'b0;
    repeat (5) @(posedge clock);
    u_ssc_ctl_model.ticks(3);
    @(posedge clock);
    sys_rst <= 1'b0;
    step(2);
    powerOn();
    configRun();
    sleepShort();
    sleepLong();
    progPins();
    tally_and_finish();
  end
endmodule

`default_nettype wire
